// >>> hw/pmsd_divider.sv
// One programmable post-divider producing a system clock level and tick
`timescale 1ns/1ps
module pmsd_divider #(
  parameter int unsigned WIDTH = 5
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Control
  input  wire logic             src_tick,
  input  wire logic             on,
  input  wire logic             align,
  input  wire logic [WIDTH-1:0] ratio,
  // Output
  output logic                  level,
  output logic                  tick
);

  initial begin
    if (WIDTH < 1 || WIDTH > 16) begin
      $error("pmsd_divider: WIDTH out of range");
    end
  end

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic             level;
    logic             tick;
  } pmsd_div_state_t;

  pmsd_div_state_t q_ff;
  pmsd_div_state_t nxt_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Divide by ratio + 1; level is high for the first half, rounded up
  always_comb begin
    nxt_q      = q_ff;
    nxt_q.tick = 1'b0;
    if (!on) begin
      // Parked low so the downstream domain sees a static clock
      nxt_q.count = '0;
      nxt_q.level = 1'b0;
    end else if (align) begin
      nxt_q.count = '0;
      nxt_q.level = 1'b1;
    end else if (src_tick) begin
      if (q_ff.count == ratio) begin
        nxt_q.count = '0;
        nxt_q.tick  = 1'b1;
      end else begin
        nxt_q.count = q_ff.count + 1'b1;
      end
      nxt_q.level = (nxt_q.count <= (ratio >> 1));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign level = q_ff.level;
  assign tick  = q_ff.tick;

endmodule : pmsd_divider

// >>> hw/pmsd_pkg.sv
// Shared constants, types and helpers of the loop multiplier and system clock dividers
package pmsd_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned MULT_W   = 5;
  localparam int unsigned RATIO_W  = 5;
  localparam int unsigned NUM_DIV  = 3;
  localparam int unsigned FACTOR_W = MULT_W + 1;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFS_LOOP_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MULTIPLY  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DIV_ONE   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DIV_TWO   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_DIV_THREE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_GO_CMD    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_GO_STAT   = 8'h18;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned LOOP_EN_BIT = 0;
  localparam int unsigned DIV_ON_BIT  = 15;
  localparam int unsigned GO_BIT      = 0;
  localparam int unsigned BUSY_BIT    = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values; index 0 is the first controller, index 1 the second
  localparam logic             LOOP_EN_RST       = 1'b0;
  localparam logic [MULT_W-1:0]  MULT_RST_FIRST  = 5'h10;
  localparam logic [MULT_W-1:0]  MULT_RST_SECOND = 5'h13;
  localparam logic [RATIO_W-1:0] DIV1_RST_FIRST  = 5'h00;
  localparam logic [RATIO_W-1:0] DIV1_RST_SECOND = 5'h01;
  localparam logic [RATIO_W-1:0] DIV2_RST_FIRST  = 5'h02;
  localparam logic [RATIO_W-1:0] DIV2_RST_SECOND = 5'h09;
  localparam logic [RATIO_W-1:0] DIV3_RST        = 5'h05;
  localparam logic [NUM_DIV-1:0] DIV_ON_RST      = 3'h6;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 40;

  ////////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {GO_IDLE, GO_LOAD, GO_ALIGN} pmsd_go_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } pmsd_bus_req_t;

  typedef struct packed {
    logic [NUM_DIV-1:0] level;
    logic [NUM_DIV-1:0] tick;
  } pmsd_sysclk_t;

  // Divider register word: enable at bit 15, ratio in the low bits, rest zero
  function automatic logic [DATA_W-1:0] pmsd_div_word(input logic on, input logic [RATIO_W-1:0] ratio);
    logic [DATA_W-1:0] w;
    w = '0;
    w[DIV_ON_BIT] = on;
    w[RATIO_W-1:0] = ratio;
    return w;
  endfunction : pmsd_div_word

endpackage : pmsd_pkg

// >>> hw/pmsd_top.sv
// Loop multiplier and three system clock post-dividers (two in the second controller) with register port and GO alignment
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module pmsd_top
  import pmsd_pkg::*;
#(
  parameter int unsigned INSTANCE = 0,
  parameter int unsigned RATIO_W_P = pmsd_pkg::RATIO_W
) (
  // Clock and reset
  input  wire logic                   CLK,
  input  wire logic                   RST_N,
  // Register port
  input  wire pmsd_pkg::pmsd_bus_req_t BUS_REQ,
  output logic [pmsd_pkg::DATA_W-1:0] RDATA,
  // Reference clock enable used in bypass
  input  wire logic                   REF_TICK,
  // Toward the loop
  output logic [pmsd_pkg::FACTOR_W-1:0] PLL_MULT_FACTOR,
  output logic                        PLL_BYPASS,
  // System clocks and status
  output pmsd_pkg::pmsd_sysclk_t      SYS_CLK,
  output logic                        GO_BUSY
);

  import pmsd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  initial begin
    if (INSTANCE > 1) begin
      $error("pmsd_top: INSTANCE must be 0 or 1");
    end
    if (RATIO_W_P != RATIO_W) begin
      $error("pmsd_top: ratio width must match the register field");
    end
  end

  // The second controller has no third divider
  localparam logic HAS_DIV3 = (INSTANCE == 0);

  ////////////////////////////////////////////////////////////////////////////////
  // Per-instance reset values

  localparam logic [MULT_W-1:0] MULT_RST =
    (INSTANCE == 0) ? MULT_RST_FIRST : MULT_RST_SECOND;

  localparam logic [RATIO_W-1:0] DIV1_RST =
    (INSTANCE == 0) ? DIV1_RST_FIRST : DIV1_RST_SECOND;

  localparam logic [RATIO_W-1:0] DIV2_RST =
    (INSTANCE == 0) ? DIV2_RST_FIRST : DIV2_RST_SECOND;

  localparam logic [RATIO_W-1:0] DIV3_RST_I =
    HAS_DIV3 ? DIV3_RST : '0;

  localparam logic [NUM_DIV-1:0] DIV_ON_RST_I =
    HAS_DIV3 ? DIV_ON_RST : (DIV_ON_RST & 3'h3);

  localparam logic [NUM_DIV-1:0][RATIO_W-1:0] RATIO_RST = {DIV3_RST_I, DIV2_RST, DIV1_RST};

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic                            loop_en;
    logic [MULT_W-1:0]               mult;
    logic [NUM_DIV-1:0]              div_on;
    logic [NUM_DIV-1:0][RATIO_W-1:0] div_ratio;
    logic [NUM_DIV-1:0][RATIO_W-1:0] act_ratio;
    pmsd_go_state_t                  go_st;
    logic                            align;
    logic [FACTOR_W-1:0]             factor;
    logic [DATA_W-1:0]               rdata;
  } pmsd_top_state_t;

  localparam pmsd_top_state_t STATE_RST = '{
    loop_en:   LOOP_EN_RST,
    mult:      MULT_RST,
    div_on:    DIV_ON_RST_I,
    div_ratio: RATIO_RST,
    act_ratio: RATIO_RST,
    go_st:     GO_IDLE,
    align:     1'b0,
    factor:    {FACTOR_W{1'b0}} + FACTOR_W'(1),
    rdata:     '0
  };

  pmsd_top_state_t q_ff;
  pmsd_top_state_t nxt_q;

  logic                  go_req;
  logic                  src_tick;
  logic [NUM_DIV-1:0]    div_level;
  logic [NUM_DIV-1:0]    div_tick;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode

  // Only a one in the go bit starts a sequence; a zero write is harmless
  assign go_req = BUS_REQ.wr && (BUS_REQ.addr == OFS_GO_CMD) && BUS_REQ.wdata[GO_BIT];

  // Bypass feeds the dividers from the reference, loop mode from the multiplied clock
  assign src_tick = q_ff.loop_en ? 1'b1 : REF_TICK;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nxt_q       = q_ff;
    nxt_q.align = 1'b0;

    // Register writes; only implemented fields are stored
    if (BUS_REQ.wr) begin
      case (BUS_REQ.addr)
        OFS_LOOP_CTRL: begin
          nxt_q.loop_en = BUS_REQ.wdata[LOOP_EN_BIT];
        end
        OFS_MULTIPLY: begin
          // No range check: the valid set depends on the loop fitted
          nxt_q.mult = BUS_REQ.wdata[MULT_W-1:0];
        end
        OFS_DIV_ONE: begin
          nxt_q.div_on[0]    = BUS_REQ.wdata[DIV_ON_BIT];
          nxt_q.div_ratio[0] = BUS_REQ.wdata[RATIO_W-1:0];
        end
        OFS_DIV_TWO: begin
          nxt_q.div_on[1]    = BUS_REQ.wdata[DIV_ON_BIT];
          nxt_q.div_ratio[1] = BUS_REQ.wdata[RATIO_W-1:0];
        end
        OFS_DIV_THREE: begin
          if (HAS_DIV3) begin
            nxt_q.div_on[2]    = BUS_REQ.wdata[DIV_ON_BIT];
            nxt_q.div_ratio[2] = BUS_REQ.wdata[RATIO_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Go sequence: load all ratios together, then restart all counters together
    case (q_ff.go_st)
      GO_IDLE: begin
        if (go_req) begin
          nxt_q.go_st = GO_LOAD;
        end
      end
      GO_LOAD: begin
        // Sampled one cycle after the go write so a ratio written just before is included
        nxt_q.act_ratio = q_ff.div_ratio;
        nxt_q.go_st     = GO_ALIGN;
      end
      GO_ALIGN: begin
        nxt_q.align = 1'b1;
        nxt_q.go_st = GO_IDLE;
      end
      default: begin
        nxt_q.go_st = GO_IDLE;
      end
    endcase

    // Factor presented to the loop; bypass leaves it at one
    if (q_ff.loop_en) begin
      nxt_q.factor = {1'b0, q_ff.mult} + FACTOR_W'(1);
    end else begin
      nxt_q.factor = FACTOR_W'(1);
    end

    // Read data stands only in the cycle after the strobe
    nxt_q.rdata = '0;
    if (BUS_REQ.rd) begin
      case (BUS_REQ.addr)
        OFS_LOOP_CTRL: begin
          nxt_q.rdata[LOOP_EN_BIT] = q_ff.loop_en;
        end
        OFS_MULTIPLY: begin
          nxt_q.rdata[MULT_W-1:0] = q_ff.mult;
        end
        OFS_DIV_ONE: begin
          nxt_q.rdata = pmsd_div_word(q_ff.div_on[0], q_ff.div_ratio[0]);
        end
        OFS_DIV_TWO: begin
          nxt_q.rdata = pmsd_div_word(q_ff.div_on[1], q_ff.div_ratio[1]);
        end
        OFS_DIV_THREE: begin
          if (HAS_DIV3) begin
            nxt_q.rdata = pmsd_div_word(q_ff.div_on[2], q_ff.div_ratio[2]);
          end
        end
        OFS_GO_CMD: begin
          nxt_q.rdata[GO_BIT] = (q_ff.go_st != GO_IDLE);
        end
        OFS_GO_STAT: begin
          nxt_q.rdata[BUSY_BIT] = (q_ff.go_st != GO_IDLE);
        end
        default: begin
          nxt_q.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      q_ff <= STATE_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Dividers

  genvar gi;
  generate
    for (gi = 0; gi < NUM_DIV; gi++) begin : g_div
      if (gi < 2 || HAS_DIV3) begin : g_present
        pmsd_divider #(
          .WIDTH (RATIO_W)
        ) u_div (
          .clk      (CLK),
          .rst_n    (RST_N),
          .src_tick (src_tick),
          .on       (q_ff.div_on[gi]),
          .align    (q_ff.align),
          .ratio    (q_ff.act_ratio[gi]),
          .level    (div_level[gi]),
          .tick     (div_tick[gi])
        );
      end else begin : g_absent
        assign div_level[gi] = 1'b0;
        assign div_tick[gi]  = 1'b0;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign RDATA           = q_ff.rdata;
  assign PLL_MULT_FACTOR = q_ff.factor;
  assign PLL_BYPASS      = ~q_ff.loop_en;
  assign SYS_CLK.level   = div_level;
  assign SYS_CLK.tick    = div_tick;
  assign GO_BUSY         = (q_ff.go_st != GO_IDLE);

endmodule : pmsd_top

// >>> verification/pmsd_checker.sv
// Port assertions of the multiplier and divider block
`timescale 1ns/1ps
module pmsd_checker
  import pmsd_pkg::*;
(
  // Clock and reset
  input wire logic                          CLK,
  input wire logic                          RST_N,
  // Register port
  input wire pmsd_pkg::pmsd_bus_req_t       BUS_REQ,
  input wire logic [pmsd_pkg::DATA_W-1:0]   RDATA,
  input wire logic                          REF_TICK,
  // Loop and clocks
  input wire logic [pmsd_pkg::FACTOR_W-1:0] PLL_MULT_FACTOR,
  input wire logic                          PLL_BYPASS,
  input wire pmsd_pkg::pmsd_sysclk_t        SYS_CLK,
  input wire logic                          GO_BUSY
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic [1:0] on_ff;
  logic [1:0] nxt_on;
  logic       go_req;
  logic       go_zero;
  logic       div_rd;
  assign go_req  = BUS_REQ.wr && BUS_REQ.addr == OFS_GO_CMD && BUS_REQ.wdata[GO_BIT] && !GO_BUSY;
  assign go_zero = BUS_REQ.wr && BUS_REQ.addr == OFS_GO_CMD && !BUS_REQ.wdata[GO_BIT] && !GO_BUSY;
  assign div_rd  = BUS_REQ.rd && BUS_REQ.addr inside {OFS_DIV_ONE, OFS_DIV_TWO, OFS_DIV_THREE};
  // Enables act without go, so they are mirrored straight from the bus
  always_comb begin
    nxt_on = on_ff;
    if (BUS_REQ.wr && BUS_REQ.addr == OFS_DIV_ONE) nxt_on[0] = BUS_REQ.wdata[DIV_ON_BIT];
    if (BUS_REQ.wr && BUS_REQ.addr == OFS_DIV_TWO) nxt_on[1] = BUS_REQ.wdata[DIV_ON_BIT];
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) on_ff <= 2'h2;
    else on_ff <= nxt_on;
  end
  sequence s_busy_two;
    GO_BUSY [*2] ##1 !GO_BUSY;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_go_seq: assert property (go_req |=> s_busy_two)
    else $error("go sequence wrong");
  a_go_zero: assert property (go_zero |=> !GO_BUSY)
    else $error("go zero started");
  a_busy_cause: assert property ($rose(GO_BUSY) |-> $past(go_req))
    else $error("busy without go");
  // The align pulse is registered once more inside each divider, so levels rise one cycle after busy falls
  a_align_high: assert property ($fell(GO_BUSY) |=> (SYS_CLK.level[1:0] & $past(on_ff)) == $past(on_ff))
    else $error("no phase alignment");
  a_div_off: assert property (!on_ff[0] && !$past(on_ff[0]) |-> !SYS_CLK.level[0] && !SYS_CLK.tick[0])
    else $error("disabled clock moves");
  a_bypass_factor: assert property (PLL_BYPASS && $past(PLL_BYPASS) |-> PLL_MULT_FACTOR == 6'h01)
    else $error("factor in bypass");
  a_mult_resv: assert property (BUS_REQ.rd && BUS_REQ.addr == OFS_MULTIPLY |=> RDATA[31:5] == 27'h0)
    else $error("multiplier reserved bits");
  a_div_resv: assert property (div_rd |=> RDATA[14:5] == 10'h0 && RDATA[31:16] == 16'h0)
    else $error("divider reserved bits");
  a_rdata_idle: assert property (!$past(BUS_REQ.rd) |-> RDATA == 32'h0)
    else $error("read data outside read");
endmodule : pmsd_checker

bind pmsd_top pmsd_checker u_chk (.CLK(CLK), .RST_N(RST_N), .BUS_REQ(BUS_REQ), .RDATA(RDATA), .REF_TICK(REF_TICK),
  .PLL_MULT_FACTOR(PLL_MULT_FACTOR), .PLL_BYPASS(PLL_BYPASS), .SYS_CLK(SYS_CLK), .GO_BUSY(GO_BUSY));

// >>> verification/pmsd_tb_top.sv
// Self-checking bench of the multiplier and system clock dividers
`timescale 1ns/1ps
module pmsd_tb_top;
  import pmsd_pkg::*;
  logic                clk;
  logic                rst_n;
  logic                ref_tick;
  logic                ref_run;
  pmsd_bus_req_t       req;
  logic [DATA_W-1:0]   rd0, rd1, r0, r1;
  logic [FACTOR_W-1:0] fac0;
  logic                byp0;
  logic                busy0;
  pmsd_sysclk_t        sc0;
  int                  n_mismatch = 0;
  int                  compares = 0;
  int                  cyc = 0;
  pmsd_top #(.INSTANCE(0)) dut (.CLK(clk), .RST_N(rst_n), .BUS_REQ(req), .RDATA(rd0), .REF_TICK(ref_tick),
    .PLL_MULT_FACTOR(fac0), .PLL_BYPASS(byp0), .SYS_CLK(sc0), .GO_BUSY(busy0));
  pmsd_top #(.INSTANCE(1)) dut_two (.CLK(clk), .RST_N(rst_n), .BUS_REQ(req), .RDATA(rd1), .REF_TICK(ref_tick),
    .PLL_MULT_FACTOR(), .PLL_BYPASS(), .SYS_CLK(), .GO_BUSY());
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Reference enable toggles every cycle while running
  always @(posedge clk) ref_tick <= ref_run & ~ref_tick;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    r0 = rd0;
    r1 = rd1;
  endtask : rd
  task automatic go();
    wr(OFS_GO_CMD, 32'h1);
    #1 chk("busy", 32'h1, 32'(busy0));
    repeat (2) @(posedge clk);
    #1 chk("busy", 32'h0, 32'(busy0));
  endtask : go
  // Sixteen cycles hold whole periods of every ratio used here
  task automatic meas(input int i, input int et, input int eh);
    int nt, nh;
    nt = 0;
    nh = 0;
    repeat (16) begin
      @(posedge clk);
      #1;
      if (sc0.tick[i] === 1'b1) nt++;
      if (sc0.level[i] === 1'b1) nh++;
    end
    chk("ticks", 32'(et), 32'(nt));
    chk("highs", 32'(eh), 32'(nh));
  endtask : meas
  task automatic conclude();
    if (n_mismatch == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(OFS_MULTIPLY);
    chk("mult0", 32'h10, r0);
    chk("mult1", 32'h13, r1);
    rd(OFS_DIV_ONE);
    chk("div1a", 32'h0, r0);
    chk("div1b", 32'h1, r1);
    rd(OFS_DIV_TWO);
    chk("div2a", 32'h8002, r0);
    chk("div2b", 32'h8009, r1);
    rd(OFS_DIV_THREE);
    chk("div3a", 32'h8005, r0);
    chk("div3b", 32'h0, r1);
    rd(8'h40);
    chk("unmapped", 32'h0, r0);
    chk("bypass", 32'h1, 32'(byp0));
    chk("factor", 32'h1, 32'(fac0));
  endtask : t_reset
  task automatic t_resv();
    wr(OFS_MULTIPLY, 32'hFFFFFFFF);
    rd(OFS_MULTIPLY);
    chk("mult", 32'h1F, r0);
    wr(OFS_DIV_ONE, 32'h7FFF7FE0);
    rd(OFS_DIV_ONE);
    chk("div1", 32'h0, r1);
    wr(OFS_DIV_THREE, 32'hFFFFFFFF);
    rd(OFS_DIV_THREE);
    chk("div3a", 32'h801F, r0);
    chk("div3b", 32'h0, r1);
    wr(OFS_DIV_THREE, 32'h5);
  endtask : t_resv
  task automatic t_factor();
    wr(OFS_LOOP_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    #1 chk("factor", 32'h20, 32'(fac0));
    chk("bypass", 32'h0, 32'(byp0));
    rd(OFS_LOOP_CTRL);
    chk("loop_en", 32'h1, r0);
    wr(OFS_MULTIPLY, 32'h7);
    repeat (2) @(posedge clk);
    #1 chk("factor", 32'h8, 32'(fac0));
  endtask : t_factor
  task automatic t_div();
    wr(OFS_DIV_ONE, 32'h8003);
    wr(OFS_DIV_TWO, 32'h8000);
    wr(OFS_GO_CMD, 32'h0);
    #1 chk("busy", 32'h0, 32'(busy0));
    go();
    // Align restarts the count, so the first wrap lands four source ticks later
    meas(0, 3, 8);
    meas(1, 16, 16);
    meas(2, 0, 0);
    wr(OFS_DIV_ONE, 32'h8001);
    meas(0, 4, 8);
    go();
    meas(0, 7, 8);
    wr(OFS_DIV_ONE, 32'h1);
    repeat (2) @(posedge clk);
    meas(0, 0, 0);
  endtask : t_div
  task automatic t_bypass();
    wr(OFS_LOOP_CTRL, 32'h0);
    wr(OFS_DIV_ONE, 32'h8001);
    go();
    meas(0, 0, 16);
    chk("factor", 32'h1, 32'(fac0));
    ref_run = 1'b1;
    repeat (2) @(posedge clk);
    meas(0, 4, 8);
  endtask : t_bypass
  initial begin
    req      = '0;
    rst_n    = 1'b0;
    ref_tick = 1'b0;
    ref_run  = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_resv();
    t_factor();
    t_div();
    t_bypass();
    conclude();
  end
endmodule : pmsd_tb_top
